/* File: design/scpc_regs.svh */
// Purpose: register offsets, field positions and reset values of the serial pin control block
// Assumes: 32-bit AXI4-Lite words, 8-bit byte address
// Notes: every field sits in byte lane 0
`ifndef SCPC_REGS_SVH
`define SCPC_REGS_SVH

`define SCPC_ADDR_W 8
`define SCPC_MCTL0_OFS 8'h00
`define SCPC_FCTL0_OFS 8'h04
`define SCPC_MSTAT0_OFS 8'h08
`define SCPC_MCTL1_OFS 8'h0c
`define SCPC_FCTL1_OFS 8'h10
`define SCPC_MSTAT1_OFS 8'h14
`define SCPC_PCTL_OFS 8'h18
`define SCPC_PSTAT_OFS 8'h1c
`define SCPC_IRQ_STAT_OFS 8'h20
`define SCPC_IRQ_EN_OFS 8'h24
`define SCPC_IRQ_CLR_OFS 8'h28

`define SCPC_MCTL_RTS_BIT 1
`define SCPC_MCTL_LOOP_BIT 4
`define SCPC_FCTL_FIFO_EN_BIT 0
`define SCPC_FCTL_DMA_SEL_BIT 3
`define SCPC_MSTAT_RING_EDGE_BIT 2
`define SCPC_MSTAT_RING_LEVEL_BIT 6
`define SCPC_PCTL_SELECT_BIT 0
`define SCPC_PSTAT_SELECTED_BIT 0
`define SCPC_PSTAT_LINE_BIT 1

`define SCPC_CTL_RESET 8'h00
`define SCPC_IRQ_W 4
`define SCPC_IRQ_RESET 4'h0
`define SCPC_RESP_OKAY 2'b00
`define SCPC_RESP_SLVERR 2'b10

`endif

/* File: design/scpc_pkg.sv */
// Purpose: shared types of the serial pin control block
// Assumes: nothing beyond the register header
// Notes: one-hot codes are written out
package scpc_pkg;
   typedef enum logic [1:0] {
      scpc_dma_single = 2'b01,
      scpc_dma_multi = 2'b10
   } scpc_dma_mode_t;
endpackage

/* File: design/scpc_irq.sv */
// Purpose: sticky interrupt status with enable and write-one-to-clear
// Assumes: events are one-cycle pulses
// Notes: a set beats a clear here; scpc_top masks event_pulse with the status, so a clear of a set bit wins
`timescale 1ns/10ps
module scpc_irq #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // events and software control
   input wire logic [W-1:0] event_pulse,
   input wire logic [W-1:0] enable,
   input wire logic [W-1:0] clear,
   // state
   output logic [W-1:0] status_q,
   output logic irq_q
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~clear) | event_pulse;
      end
   end

   // registered so the output comes from a flop; one cycle behind status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & enable);
      end
   end
endmodule

/* File: design/scpc_channel.sv */
// Purpose: pin behaviour of one serial channel
// Assumes: pin inputs synchronous to aclk
// Notes: receiver and transmitter datapaths live outside
`timescale 1ns/10ps
module scpc_channel
   import scpc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control bits
   input wire logic request_send_control_bit,
   input wire logic loop_mode,
   input wire logic fifo_enable_bit,
   input wire logic dma_mode_select_bit,
   input wire logic mstat_read,
   // receiver and transmitter state
   input wire logic rx_has_data,
   input wire logic rx_trigger,
   input wire logic rx_timeout,
   input wire logic tx_enabled,
   input wire logic tx_empty,
   input wire logic tx_bit,
   // pins
   input wire logic ring_in,
   input wire logic serial_input_pin,
   output logic rts_n_q,
   output logic receiver_dma_ready_n_q,
   output logic serial_output_pin_q,
   output logic rx_serial_q,
   output logic ring_level_q,
   output logic ring_trailing_edge_flag_q,
   output logic rx_ready_event
);
   scpc_dma_mode_t mode;
   logic ring_prev_q;
   logic ring_fall;
   logic rdy_n_d;

   // fifo off forces single transfer mode
   assign mode = (fifo_enable_bit && dma_mode_select_bit) ? scpc_dma_multi
                                                         : scpc_dma_single;

   always_comb begin
      rdy_n_d = receiver_dma_ready_n_q;
      case (mode)
         scpc_dma_single: rdy_n_d = !rx_has_data;
         scpc_dma_multi: begin
            if (!rx_has_data) begin
               rdy_n_d = 1'b1;
            end else if (rx_trigger || rx_timeout) begin
               rdy_n_d = 1'b0;
            end
         end
         default: rdy_n_d = 1'b1;
      endcase
   end

   assign rx_ready_event = receiver_dma_ready_n_q && !rdy_n_d && aresetn;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receiver_dma_ready_n_q <= 1'b1;
      end else begin
         receiver_dma_ready_n_q <= rdy_n_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rts_n_q <= 1'b1;
      end else begin
         rts_n_q <= !request_send_control_bit;
      end
   end

   // high is mark; loop mode feeds the transmitter back instead of the pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_serial_q <= 1'b1;
         serial_output_pin_q <= 1'b1;
      end else begin
         rx_serial_q <= loop_mode ? tx_bit : serial_input_pin;
         serial_output_pin_q <= (!tx_enabled || tx_empty || loop_mode) ? 1'b1 : tx_bit;
      end
   end

   assign ring_fall = ring_prev_q && !ring_in;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ring_prev_q <= 1'b0;
         ring_level_q <= 1'b0;
      end else begin
         ring_prev_q <= ring_in;
         ring_level_q <= ring_in;
      end
   end

   // a fall in the read cycle survives the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ring_trailing_edge_flag_q <= 1'b0;
      end else if (ring_fall) begin
         ring_trailing_edge_flag_q <= 1'b1;
      end else if (mstat_read) begin
         ring_trailing_edge_flag_q <= 1'b0;
      end
   end
endmodule

/* File: design/scpc_top.sv */
// Purpose: two serial channels' pin control and printer select, behind AXI4-Lite
// Assumes: single clock aclk at 125 MHz, synchronous active-low reset
// Notes: receiver fifo state and transmitter bit come from the datapath outside
`timescale 1ns/10ps
`include "scpc_regs.svh"

// Function
// - rts low while request bit set
// - reset forces both rts high
// - dma mode select only with fifo on
// - mode 0 ready low while data held
// - mode 0 ready high once empty
// - mode 1 ready low at trigger/timeout
// - mode 1 ready held until empty
// - ring level readable in status bit 6
// - ring falling edge flag in bit 2
// - serial input high mark, low space
// - loop mode ignores serial input pin
// - serial output mark when idle or reset
// - open-drain select line, low selects
module scpc_top
   import scpc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [`SCPC_ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [`SCPC_ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // receiver and transmitter state, one bit per channel
   input wire logic [1:0] rx_has_data,
   input wire logic [1:0] rx_trigger,
   input wire logic [1:0] rx_timeout,
   input wire logic [1:0] tx_enabled,
   input wire logic [1:0] tx_empty,
   input wire logic [1:0] tx_bit,
   // serial pins
   input wire logic [1:0] ring_in,
   input wire logic [1:0] serial_input_pin,
   output logic [1:0] rts_n,
   output logic [1:0] receiver_dma_ready_n,
   output logic [1:0] serial_output_pin,
   output logic [1:0] rx_serial,
   // printer pins
   input wire logic printer_selected_input,
   input wire logic printer_select_line_i,
   output logic printer_select_line_o,
   output logic printer_select_line_oe,
   // interrupt
   output logic irq
);
   // write channel state
   logic aw_held_q;
   logic w_held_q;
   logic [`SCPC_ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic aw_take;
   logic w_take;
   logic do_write;
   logic wr_lane0;
   logic wr_hit;
   // read channel state
   logic ar_take;
   logic [31:0] rd_data;
   logic rd_hit;
   // control registers
   logic [7:0] mctl_q [2];
   logic [7:0] fctl_q [2];
   logic pctl_q;
   logic [`SCPC_IRQ_W-1:0] irq_en_q;
   logic [`SCPC_IRQ_W-1:0] irq_clr;
   logic [`SCPC_IRQ_W-1:0] irq_status;
   logic [`SCPC_IRQ_W-1:0] irq_event;
   // per channel status
   logic [1:0] mstat_read;
   logic [1:0] ring_level;
   logic [1:0] ring_edge;
   logic [1:0] ring_edge_q;
   logic [1:0] rx_ready_event;
   logic selected_q;
   logic line_q;

   assign aw_take = awvalid && awready;
   assign w_take = wvalid && wready;
   assign ar_take = arvalid && arready;
   assign do_write = aw_held_q && w_held_q && !bvalid;
   assign wr_lane0 = w_strb_q[0];

   // address and data may arrive in either order; each is held until both are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (aw_take) begin
         aw_held_q <= 1'b1;
         aw_addr_q <= awaddr;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (w_take) begin
         w_held_q <= 1'b1;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end
   end

   // ready drops while a word is held or its response is pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
      end else begin
         awready <= !aw_take && !(aw_held_q && !do_write) && !(bvalid && !bready);
         wready <= !w_take && !(w_held_q && !do_write) && !(bvalid && !bready);
      end
   end

   // address decode for writes
   always_comb begin
      wr_hit = 1'b1;
      if (aw_addr_q == `SCPC_MCTL0_OFS) begin
         wr_hit = 1'b1;
      end else if (aw_addr_q == `SCPC_FCTL0_OFS) begin
         wr_hit = 1'b1;
      end else if (aw_addr_q == `SCPC_MCTL1_OFS) begin
         wr_hit = 1'b1;
      end else if (aw_addr_q == `SCPC_FCTL1_OFS) begin
         wr_hit = 1'b1;
      end else if (aw_addr_q == `SCPC_PCTL_OFS) begin
         wr_hit = 1'b1;
      end else if (aw_addr_q == `SCPC_IRQ_EN_OFS) begin
         wr_hit = 1'b1;
      end else if (aw_addr_q == `SCPC_IRQ_CLR_OFS) begin
         wr_hit = 1'b1;
      end else if (aw_addr_q == `SCPC_MSTAT0_OFS || aw_addr_q == `SCPC_MSTAT1_OFS) begin
         wr_hit = 1'b1;
      end else if (aw_addr_q == `SCPC_PSTAT_OFS || aw_addr_q == `SCPC_IRQ_STAT_OFS) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `SCPC_RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? `SCPC_RESP_OKAY : `SCPC_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // each channel keeps its own modem and fifo control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mctl_q[0] <= `SCPC_CTL_RESET;
         mctl_q[1] <= `SCPC_CTL_RESET;
         fctl_q[0] <= `SCPC_CTL_RESET;
         fctl_q[1] <= `SCPC_CTL_RESET;
      end else if (do_write && wr_lane0) begin
         if (aw_addr_q == `SCPC_MCTL0_OFS) begin
            mctl_q[0] <= w_data_q[7:0];
         end else if (aw_addr_q == `SCPC_FCTL0_OFS) begin
            fctl_q[0] <= w_data_q[7:0];
         end else if (aw_addr_q == `SCPC_MCTL1_OFS) begin
            mctl_q[1] <= w_data_q[7:0];
         end else if (aw_addr_q == `SCPC_FCTL1_OFS) begin
            fctl_q[1] <= w_data_q[7:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pctl_q <= 1'b0;
         irq_en_q <= `SCPC_IRQ_RESET;
      end else if (do_write && wr_lane0) begin
         if (aw_addr_q == `SCPC_PCTL_OFS) begin
            pctl_q <= w_data_q[`SCPC_PCTL_SELECT_BIT];
         end else if (aw_addr_q == `SCPC_IRQ_EN_OFS) begin
            irq_en_q <= w_data_q[`SCPC_IRQ_W-1:0];
         end
      end
   end

   // the clear register stores nothing; a write is a one-cycle clear pulse
   assign irq_clr = (do_write && wr_lane0 && aw_addr_q == `SCPC_IRQ_CLR_OFS)
                    ? w_data_q[`SCPC_IRQ_W-1:0] : '0;

   // reading a modem status register clears its edge flag
   assign mstat_read[0] = ar_take && araddr == `SCPC_MSTAT0_OFS;
   assign mstat_read[1] = ar_take && araddr == `SCPC_MSTAT1_OFS;

   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_ch
         scpc_channel u_channel (
            .aclk(aclk),
            .aresetn(aresetn),
            .request_send_control_bit(mctl_q[ch][`SCPC_MCTL_RTS_BIT]),
            .loop_mode(mctl_q[ch][`SCPC_MCTL_LOOP_BIT]),
            .fifo_enable_bit(fctl_q[ch][`SCPC_FCTL_FIFO_EN_BIT]),
            .dma_mode_select_bit(fctl_q[ch][`SCPC_FCTL_DMA_SEL_BIT]),
            .mstat_read(mstat_read[ch]),
            .rx_has_data(rx_has_data[ch]),
            .rx_trigger(rx_trigger[ch]),
            .rx_timeout(rx_timeout[ch]),
            .tx_enabled(tx_enabled[ch]),
            .tx_empty(tx_empty[ch]),
            .tx_bit(tx_bit[ch]),
            .ring_in(ring_in[ch]),
            .serial_input_pin(serial_input_pin[ch]),
            .rts_n_q(rts_n[ch]),
            .receiver_dma_ready_n_q(receiver_dma_ready_n[ch]),
            .serial_output_pin_q(serial_output_pin[ch]),
            .rx_serial_q(rx_serial[ch]),
            .ring_level_q(ring_level[ch]),
            .ring_trailing_edge_flag_q(ring_edge[ch]),
            .rx_ready_event(rx_ready_event[ch])
         );
      end
   endgenerate

   // ring edge events and receiver ready activations raise the interrupt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_event <= '0;
         ring_edge_q <= '0;
      end else begin
         ring_edge_q <= ring_edge;
         irq_event <= {rx_ready_event, ring_edge & ~ring_edge_q};
      end
   end

   scpc_irq #(
      .W(`SCPC_IRQ_W)
   ) u_irq (
      .aclk(aclk),
      .aresetn(aresetn),
      .event_pulse(irq_event & ~irq_status),
      .enable(irq_en_q),
      .clear(irq_clr),
      .status_q(irq_status),
      .irq_q(irq)
   );

   // select line is open drain: only ever pulled low, released otherwise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         printer_select_line_o <= 1'b0;
         printer_select_line_oe <= 1'b0;
      end else begin
         printer_select_line_o <= 1'b0;
         printer_select_line_oe <= pctl_q;
      end
   end

   // printer reports selection by driving its input high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         selected_q <= 1'b0;
         line_q <= 1'b1;
      end else begin
         selected_q <= printer_selected_input;
         line_q <= printer_select_line_i;
      end
   end

   // read data mux
   always_comb begin
      rd_data = '0;
      rd_hit = 1'b1;
      if (araddr == `SCPC_MCTL0_OFS) begin
         rd_data[7:0] = mctl_q[0];
      end else if (araddr == `SCPC_FCTL0_OFS) begin
         rd_data[7:0] = fctl_q[0];
      end else if (araddr == `SCPC_MSTAT0_OFS) begin
         rd_data[`SCPC_MSTAT_RING_LEVEL_BIT] = ring_level[0];
         rd_data[`SCPC_MSTAT_RING_EDGE_BIT] = ring_edge[0];
      end else if (araddr == `SCPC_MCTL1_OFS) begin
         rd_data[7:0] = mctl_q[1];
      end else if (araddr == `SCPC_FCTL1_OFS) begin
         rd_data[7:0] = fctl_q[1];
      end else if (araddr == `SCPC_MSTAT1_OFS) begin
         rd_data[`SCPC_MSTAT_RING_LEVEL_BIT] = ring_level[1];
         rd_data[`SCPC_MSTAT_RING_EDGE_BIT] = ring_edge[1];
      end else if (araddr == `SCPC_PCTL_OFS) begin
         rd_data[`SCPC_PCTL_SELECT_BIT] = pctl_q;
      end else if (araddr == `SCPC_PSTAT_OFS) begin
         rd_data[`SCPC_PSTAT_SELECTED_BIT] = selected_q;
         rd_data[`SCPC_PSTAT_LINE_BIT] = line_q;
      end else if (araddr == `SCPC_IRQ_STAT_OFS) begin
         rd_data[`SCPC_IRQ_W-1:0] = irq_status;
      end else if (araddr == `SCPC_IRQ_EN_OFS) begin
         rd_data[`SCPC_IRQ_W-1:0] = irq_en_q;
      end else if (araddr == `SCPC_IRQ_CLR_OFS) begin
         rd_data = '0;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // read answers one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `SCPC_RESP_OKAY;
      end else if (ar_take) begin
         rvalid <= 1'b1;
         rdata <= rd_data;
         rresp <= rd_hit ? `SCPC_RESP_OKAY : `SCPC_RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
      end else begin
         arready <= !ar_take && !(rvalid && !rready);
      end
   end
endmodule

/* File: sim/scpc_partner.sv */
// Purpose: modem line and printer seen from the pins of the serial pin control block
// Assumes: bench commands ring and line levels, synchronous to aclk
// Notes: select wire has a pull-up, so a released line reads high
`timescale 1ns/10ps
module scpc_partner (
   // clock
   input wire logic aclk,
   // device pins
   input wire logic [1:0] rts_n,
   input wire logic printer_select_line_o,
   input wire logic printer_select_line_oe,
   // bench commands
   input wire logic [1:0] ring_cmd,
   input wire logic [1:0] line_cmd,
   // lines back to the device
   output logic [1:0] ring_in,
   output logic [1:0] serial_input_pin,
   output logic printer_select_line_i,
   output logic printer_selected_input = 1'b0,
   output logic [1:0] modem_ready
);
   assign printer_select_line_i = printer_select_line_oe ? printer_select_line_o : 1'b1;
   // printer answers a cycle late, as a slow part would
   always_ff @(posedge aclk) begin
      printer_selected_input <= !printer_select_line_i;
   end
   assign ring_in = ring_cmd;
   assign serial_input_pin = line_cmd;
   assign modem_ready = ~rts_n;
endmodule

/* File: sim/scpc_checker.sv */
// Purpose: port-level assertions of the serial pin control block
// Assumes: one clock, synchronous active-low reset
// Notes: register contents are hidden, so checks tie pins to their inputs
`timescale 1ns/10ps
module scpc_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   // channel state and pins
   input wire logic [1:0] rx_has_data,
   input wire logic [1:0] tx_enabled,
   input wire logic [1:0] tx_empty,
   input wire logic [1:0] rts_n,
   input wire logic [1:0] receiver_dma_ready_n,
   input wire logic [1:0] serial_output_pin,
   input wire logic printer_select_line_o,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_both_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_b_stall;
      bvalid && !bready;
   endsequence
   a_reset_pins_idle: assert property (disable iff (1'b0) !aresetn |=> rts_n == 2'b11 &&
      serial_output_pin == 2'b11 && receiver_dma_ready_n == 2'b11 && !irq)
      else $error("pins not idle after reset");
   a_serial_output_pin_mark0: assert property ((!tx_enabled[0] || tx_empty[0]) |=> serial_output_pin[0])
      else $error("channel 0 output left mark while idle");
   a_serial_output_pin_mark1: assert property ((!tx_enabled[1] || tx_empty[1]) |=> serial_output_pin[1])
      else $error("channel 1 output left mark while idle");
   a_ready_empty_high: assert property (!rx_has_data[0] |=> receiver_dma_ready_n[0])
      else $error("receiver ready active with empty receiver");
   a_ready_low_cause: assert property ($fell(receiver_dma_ready_n[1]) |-> $past(rx_has_data[1]))
      else $error("receiver ready went active without data");
   a_select_open_drain: assert property (!printer_select_line_o)
      else $error("select line driven high");
   a_write_answer: assert property (s_both_taken |-> ##[1:4] bvalid)
      else $error("write response missing");
   a_b_hold: assert property (s_b_stall |=> bvalid && $stable(bresp))
      else $error("write response dropped before accept");
   a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped before accept");
endmodule

/* File: sim/scpc_tb_top.sv */
// Purpose: self-checking bench of the serial pin control block
// Assumes: AXI4-Lite master tasks, partner model on the pins
// Notes: pins are compared a few edges after their cause, once settled
`timescale 1ns/10ps
`include "scpc_regs.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module scpc_tb_top;
   import scpc_pkg::*;
   logic aclk = 1'b0, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
   logic awready, wready, arready, irq, sel_i, sel_o, sel_oe, selected;
   logic [7:0] awaddr, araddr, mctl_m [2];
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [2:0] awprot, arprot;
   logic [1:0] bresp, rresp, rx_has_data, rx_trigger, rx_timeout, tx_enabled, tx_empty, tx_bit;
   logic [1:0] ring_cmd, line_cmd, ring_in, s_in, rts_n, rdy_n, s_out, rx_serial, modem_ready;
   int err_total = 0, compares = 0;
   initial forever #4 aclk = ~aclk;
   scpc_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .rx_has_data(rx_has_data), .rx_trigger(rx_trigger),
      .rx_timeout(rx_timeout), .tx_enabled(tx_enabled), .tx_empty(tx_empty), .tx_bit(tx_bit),
      .ring_in(ring_in), .serial_input_pin(s_in), .rts_n(rts_n), .receiver_dma_ready_n(rdy_n),
      .serial_output_pin(s_out), .rx_serial(rx_serial), .printer_selected_input(selected),
      .printer_select_line_i(sel_i), .printer_select_line_o(sel_o),
      .printer_select_line_oe(sel_oe), .irq(irq));
   scpc_partner u_partner (.aclk(aclk), .rts_n(rts_n), .printer_select_line_o(sel_o),
      .printer_select_line_oe(sel_oe), .ring_cmd(ring_cmd), .line_cmd(line_cmd),
      .ring_in(ring_in), .serial_input_pin(s_in), .printer_select_line_i(sel_i),
      .printer_selected_input(selected), .modem_ready(modem_ready));
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic check_bound(input int n);
      if (n >= 50) begin
         err_total++;
         $display("wrong value at %0t: bus handshake timed out", $time);
         report_and_stop();
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic aw_ok, w_ok;
      n = 0;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      while (!(aw_ok && w_ok) && n < 50) begin
         @(posedge aclk);
         n++;
         if (!aw_ok && awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
         if (!w_ok && wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
      end
      // a late bready makes the response stall before it is accepted
      wait_n(2);
      bready <= 1'b1;
      do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 50);
      check_bound(n);
      bready <= 1'b0;
      `CHK(bresp, `SCPC_RESP_OKAY)
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr <= a; arvalid <= 1'b1;
      do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
      arvalid <= 1'b0;
      wait_n(1);
      rready <= 1'b1;
      do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 50);
      check_bound(n);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask
   function automatic logic exp_s_out(int c);
      return (!tx_enabled[c] || tx_empty[c] || mctl_m[c][4]) ? 1'b1 : tx_bit[c];
   endfunction
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] v;
      int c;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf; awprot = '0; arprot = '0;
      rx_has_data = '0; rx_trigger = '0; rx_timeout = '0; tx_enabled = '0; tx_empty = 2'b11;
      tx_bit = '0; ring_cmd = '0; line_cmd = 2'b11; aresetn = 1'b0;
      mctl_m[0] = '0; mctl_m[1] = '0;
      void'($urandom(93));
      wait_n(20);
      `CHK({rts_n, s_out, rdy_n}, 6'h3f)
      aresetn <= 1'b1;
      wait_n(2);
      for (int i = 0; i < 4; i++) begin
         c = i % 2;
         v = (i < 2) ? 8'h02 : 8'($urandom_range(0, 1) << 1);
         axi_wr(c ? `SCPC_MCTL1_OFS : `SCPC_MCTL0_OFS, {24'h0, v});
         mctl_m[c] = v;
         wait_n(2);
         `CHK(rts_n[c], ~v[1])
         `CHK(modem_ready[c], v[1])
         `CHK(rts_n[1 - c], ~mctl_m[1 - c][1])
      end
      // modes 3 and 4 both run multi-transfer, one by trigger and one by time-out
      for (int m = 0; m < 5; m++) begin
         c = m % 2;
         axi_wr(c ? `SCPC_FCTL1_OFS : `SCPC_FCTL0_OFS, {28'h0, m >= 2, 2'b00, m == 1 || m >= 3});
         rx_has_data[c] <= 1'b1; wait_n(3);
         `CHK(rdy_n[c], m >= 3)
         if (m == 4) rx_timeout[c] <= 1'b1; else rx_trigger[c] <= 1'b1;
         wait_n(3);
         `CHK(rdy_n[c], 1'b0)
         rx_trigger[c] <= 1'b0; rx_timeout[c] <= 1'b0; wait_n(3);
         `CHK(rdy_n[c], 1'b0)
         rx_has_data[c] <= 1'b0; wait_n(3);
         `CHK(rdy_n[c], 1'b1)
      end
      axi_wr(`SCPC_IRQ_CLR_OFS, 32'hf);
      axi_wr(`SCPC_IRQ_EN_OFS, 32'h0);
      ring_cmd[0] <= 1'b1; wait_n(3);
      axi_rd(`SCPC_MSTAT0_OFS, d, r);
      `CHK({d[6], d[2]}, 2'b10)
      ring_cmd[0] <= 1'b0; wait_n(3);
      axi_rd(`SCPC_MSTAT0_OFS, d, r);
      `CHK({d[6], d[2]}, 2'b01)
      axi_rd(`SCPC_MSTAT0_OFS, d, r);
      `CHK(d[2], 1'b0)
      axi_rd(`SCPC_MSTAT1_OFS, d, r);
      `CHK(d[2], 1'b0)
      axi_rd(`SCPC_IRQ_STAT_OFS, d, r);
      `CHK({irq, d[3:0]}, 5'h01)
      axi_wr(`SCPC_IRQ_EN_OFS, 32'h1); wait_n(3);
      `CHK(irq, 1'b1)
      axi_wr(`SCPC_IRQ_CLR_OFS, 32'h1); wait_n(3);
      `CHK(irq, 1'b0)
      for (int i = 0; i < 10; i++) begin
         tx_enabled <= (i < 3) ? 2'b11 : 2'($urandom);
         tx_empty <= (i < 3) ? 2'b00 : 2'($urandom);
         tx_bit <= 2'($urandom);
         line_cmd <= 2'($urandom);
         if (i == 6) begin
            axi_wr(`SCPC_MCTL0_OFS, 32'h10);
            mctl_m[0] = 8'h10;
         end
         wait_n(3);
         for (int k = 0; k < 2; k++) begin
            `CHK(s_out[k], exp_s_out(k))
            `CHK(rx_serial[k], mctl_m[k][4] ? tx_bit[k] : line_cmd[k])
         end
      end
      axi_wr(`SCPC_PCTL_OFS, 32'h1); wait_n(3);
      `CHK(sel_oe, 1'b1)
      axi_rd(`SCPC_PSTAT_OFS, d, r);
      `CHK(d[1:0], 2'b01)
      axi_wr(`SCPC_PCTL_OFS, 32'h0); wait_n(3);
      axi_rd(`SCPC_PSTAT_OFS, d, r);
      `CHK(d[1:0], 2'b10)
      axi_rd(8'h30, d, r);
      `CHK({r, d}, {`SCPC_RESP_SLVERR, 32'h0})
      report_and_stop();
   end
endmodule
bind scpc_top scpc_checker u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
   .rx_has_data(rx_has_data), .tx_enabled(tx_enabled), .tx_empty(tx_empty), .rts_n(rts_n),
   .receiver_dma_ready_n(receiver_dma_ready_n), .serial_output_pin(serial_output_pin),
   .printer_select_line_o(printer_select_line_o), .irq(irq));
